// ===== rtl/flash_cfg_regs.sv
// flash configuration register bank: serial register transactions on the
// link clock, register storage and derived controls on core_clk
// assumes the serial front end delivers cs_n, sclk and si, and that core logic
// consumes the protection, latency and buffer controls on core_clk
`timescale 1ns/1ps
`include "flash_cfg_params.svh"
module flash_cfg_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_up,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire flash_cfg_pkg::read_kind_e read_kind,
  input wire logic [2:0] block_protect_size,
  input wire logic [15:0] prog_byte_offset,
  output logic protect_anchor_bottom,
  output logic permanent_lock,
  output logic temporary_lock,
  output logic block_protect_locked,
  output logic sector_arch_locked,
  output logic four_bit_io_select,
  output logic data_line_2_is_data,
  output logic four_byte_address_select,
  output logic [2:0] read_latency_code,
  output logic [3:0] read_dummy_cycles,
  output logic [1:0] read_mode_cycles,
  output logic blank_check_enable,
  output logic program_buffer_size_select,
  output logic [8:0] prog_buffer_index,
  output logic prot_active,
  output logic [7:0] prot_first_sector,
  output logic [7:0] prot_last_sector
);

  flash_cfg_pkg::core_s c_q, c_d;
  flash_cfg_pkg::frame_s f_q, f_d;
  flash_cfg_pkg::link_s l_q, l_d;

  function automatic logic [3:0] dummy_for(input flash_cfg_pkg::read_kind_e kind,
                                           input logic [2:0] code);
    case (kind)
      flash_cfg_pkg::RK_ARRAY,
      flash_cfg_pkg::RK_QUAD_IO,
      flash_cfg_pkg::RK_NV_REG: dummy_for = `LAT_BASE + {1'b0, code};
      flash_cfg_pkg::RK_PARAM_TABLE,
      flash_cfg_pkg::RK_UNIQUE_ID: dummy_for = `FIXED_DUMMY;
      default: dummy_for = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] reg_read_dummy(input logic [2:0] idx, input logic [2:0] code);
    reg_read_dummy = dummy_for(idx[0] ? flash_cfg_pkg::RK_VOL_REG : flash_cfg_pkg::RK_NV_REG,
                               code);
  endfunction

  function automatic logic [7:0] reg_pick(input logic [47:0] snap, input logic [2:0] idx);
    reg_pick = (idx <= `IDX_ERASE_VOL) ? snap[{idx, 3'h0} +: 8] : 8'h00;
  endfunction

  // sector count covered by a protection size code
  function automatic logic [8:0] prot_count(input logic [2:0] code);
    case (code)
      3'h0: prot_count = 9'h000;
      3'h7: prot_count = `PROT_ALL_COUNT;
      default: prot_count = `PROT_UNIT << (code - 3'h1);
    endcase
  endfunction

  // ---------------- link domain ----------------
  logic addr4;
  logic [7:0] byte_in;
  logic [3:0] n_dummy;
  logic [5:0] addr_last;
  logic [2:0] idx_now;

  always_comb begin
    f_d = f_q;
    l_d = l_q;
    addr4 = l_q.snap[{`IDX_ADDR_VOL, 3'h0} + 6'(`B_ADDR4)];
    byte_in = {f_q.sh[6:0], si};
    addr_last = addr4 ? `ADDR_BITS_4 : `ADDR_BITS_3;
    // index is still arriving during the last address bit
    idx_now = (f_q.st == flash_cfg_pkg::ST_ADDR) ? byte_in[2:0] : f_q.idx;
    n_dummy = reg_read_dummy(idx_now, l_q.snap[{`IDX_ADDR_VOL, 3'h0} +: 3]);
    l_d.rst_s1 = sys_rst;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.tgl_s1 = c_q.pub_tgl;
    l_d.tgl_s2 = l_q.tgl_s1;
    if (l_q.tgl_s2 != l_q.tgl_seen) begin
      l_d.snap = c_q.pub;
      l_d.tgl_seen = l_q.tgl_s2;
    end
    f_d.sh = byte_in;
    f_d.cnt = f_q.cnt + 6'h01;
    unique case (f_q.st)
      flash_cfg_pkg::ST_OPC: begin
        if (f_q.cnt == 6'h07) begin
          f_d.opc = byte_in;
          f_d.cnt = 6'h00;
          f_d.st = flash_cfg_pkg::ST_SKIP;
          if (byte_in == `OPC_WR_ENABLE) begin
            l_d.wel = 1'b1;
          end else if (byte_in == `OPC_WR_DISABLE) begin
            l_d.wel = 1'b0;
          end else if (byte_in == `OPC_REG_WRITE || byte_in == `OPC_REG_READ) begin
            f_d.st = flash_cfg_pkg::ST_ADDR;
          end
        end
      end
      flash_cfg_pkg::ST_ADDR: begin
        if (f_q.cnt == addr_last) begin
          f_d.idx = byte_in[2:0];
          f_d.cnt = 6'h00;
          if (f_q.opc == `OPC_REG_WRITE) begin
            f_d.st = flash_cfg_pkg::ST_DIN;
          end else if (n_dummy == 4'h0) begin
            f_d.st = flash_cfg_pkg::ST_DOUT;
            f_d.dout = reg_pick(l_q.snap, byte_in[2:0]);
          end else begin
            f_d.st = flash_cfg_pkg::ST_DUMMY;
          end
        end
      end
      flash_cfg_pkg::ST_DUMMY: begin
        if (f_q.cnt == {2'h0, n_dummy - 4'h1}) begin
          f_d.st = flash_cfg_pkg::ST_DOUT;
          f_d.dout = reg_pick(l_q.snap, f_q.idx);
          f_d.cnt = 6'h00;
        end
      end
      flash_cfg_pkg::ST_DOUT: begin
        f_d.dout = {f_q.dout[6:0], 1'b0};
        if (f_q.cnt == 6'h07) begin
          f_d.dout = reg_pick(l_q.snap, f_q.idx);
          f_d.cnt = 6'h00;
        end
      end
      flash_cfg_pkg::ST_DIN: begin
        if (f_q.cnt == 6'h07) begin
          f_d.st = flash_cfg_pkg::ST_SKIP;
          if (l_q.wel && f_q.idx <= `IDX_ERASE_VOL) begin
            l_d.wr_idx = f_q.idx;
            l_d.wr_data = byte_in;
            l_d.wr_tgl = ~l_q.wr_tgl;
            l_d.wel = 1'b0;
          end
        end
      end
      flash_cfg_pkg::ST_SKIP: begin
        f_d.cnt = f_q.cnt;
      end
    endcase
    // link side handshake state made known while reset is seen on sclk
    if (l_q.rst_s2) begin
      l_d.wel = 1'b0;
      l_d.wr_tgl = 1'b0;
      l_d.tgl_seen = l_q.tgl_s2;
      l_d.snap = c_q.pub;
    end
  end

  // frame state is cleared whenever chip select is released
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      f_q <= '{st: flash_cfg_pkg::ST_OPC, default: '0};
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge sclk) begin
    l_q <= l_d;
  end

  assign so_oe = (f_q.st == flash_cfg_pkg::ST_DOUT);
  assign so = so_oe ? f_q.dout[7] : 1'b0;

  // ---------------- core domain ----------------
  logic wr_arrive;
  logic lock_perm;
  logic lock_bp;
  logic [7:0] wd;
  logic [8:0] pcount;
  logic [47:0] cur;

  always_comb begin
    c_d = c_q;
    c_d.ack_s1 = l_q.tgl_seen;
    c_d.ack_s2 = c_q.ack_s1;
    c_d.wr_s1 = l_q.wr_tgl;
    c_d.wr_s2 = c_q.wr_s1;
    c_d.wr_s3 = c_q.wr_s2;
    wr_arrive = c_q.wr_s2 ^ c_q.wr_s3;
    wd = l_q.wr_data;
    lock_perm = c_q.nv1[`B_PERM] | c_q.v1[`B_PERM];
    lock_bp = lock_perm | c_q.v1[`B_TEMP];
    if (wr_arrive) begin
      case (l_q.wr_idx)
        `IDX_PROT_NV: begin
          if (!lock_bp) begin
            c_d.nv1[`B_ANCHOR] = wd[`B_ANCHOR];
          end
          c_d.nv1[`B_PERM] = c_q.nv1[`B_PERM] | wd[`B_PERM];
          c_d.nv1[`B_QUAD] = wd[`B_QUAD];
        end
        `IDX_PROT_VOL: begin
          c_d.v1[`B_QUAD] = wd[`B_QUAD];
          c_d.v1[`B_TEMP] = wd[`B_TEMP];
        end
        `IDX_ADDR_NV: c_d.nv2 = (c_q.nv2 & ~`ADDR_WMASK) | (wd & `ADDR_WMASK);
        `IDX_ADDR_VOL: c_d.v2 = (c_q.v2 & ~`ADDR_WMASK) | (wd & `ADDR_WMASK);
        `IDX_ERASE_NV: c_d.nv3 = (c_q.nv3 & ~`ERASE_WMASK) | (wd & `ERASE_WMASK);
        `IDX_ERASE_VOL: c_d.v3 = (c_q.v3 & ~`ERASE_WMASK) | (wd & `ERASE_WMASK);
        default: c_d.v3 = c_q.v3;
      endcase
    end
    cur = {c_q.v3, c_q.nv3, c_q.v2, c_q.nv2, c_q.v1, c_q.nv1};
    if (c_q.pub_tgl == c_q.ack_s2 && c_q.pub != cur) begin
      c_d.pub = cur;
      c_d.pub_tgl = ~c_q.pub_tgl;
    end
    c_d.dummy = dummy_for(read_kind, c_q.v2[2:0]);
    c_d.mode = (read_kind == flash_cfg_pkg::RK_QUAD_IO) ? `QUAD_MODE_CYC : 2'h0;
    c_d.buf_idx = c_q.v3[`B_PROGRAM_BUFFER_SIZE_SELECT] ? prog_byte_offset[8:0]
                                    : {1'b0, prog_byte_offset[7:0]};
    pcount = prot_count(block_protect_size);
    c_d.prot_on = (pcount != 9'h000);
    if (block_protect_size == 3'h7 || c_q.v1[`B_ANCHOR]) begin
      c_d.prot_first = 8'h00;
      c_d.prot_last = 8'(pcount - 9'h001);
    end else begin
      c_d.prot_first = 8'(`SECTOR_COUNT - pcount);
      c_d.prot_last = 8'hff;
    end
    if (sys_rst) begin
      if (power_up) begin
        c_d.nv1 = `PROT_NV_DEFAULT;
        c_d.nv2 = `ADDR_NV_DEFAULT;
        c_d.nv3 = `ERASE_NV_DEFAULT;
      end else begin
        c_d.nv1 = c_q.nv1;
        c_d.nv2 = c_q.nv2;
        c_d.nv3 = c_q.nv3;
      end
      c_d.v1 = c_d.nv1 & ~(8'h01 << `B_TEMP);
      c_d.v2 = c_d.nv2;
      c_d.v3 = c_d.nv3;
      c_d.pub = '0;
      c_d.pub_tgl = power_up ? 1'b0 : c_q.ack_s2;
      c_d.wr_s3 = c_q.wr_s2;
      c_d.dummy = 4'h0;
      c_d.mode = 2'h0;
      c_d.buf_idx = 9'h000;
      c_d.prot_on = 1'b0;
      c_d.prot_first = 8'h00;
      c_d.prot_last = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    c_q <= c_d;
  end

  assign protect_anchor_bottom = c_q.v1[`B_ANCHOR];
  assign permanent_lock = c_q.v1[`B_PERM];
  assign temporary_lock = c_q.v1[`B_TEMP];
  assign block_protect_locked = c_q.nv1[`B_PERM] | c_q.v1[`B_PERM] | c_q.v1[`B_TEMP];
  assign sector_arch_locked = c_q.nv1[`B_PERM] | c_q.v1[`B_PERM];
  assign four_bit_io_select = c_q.v1[`B_QUAD];
  assign data_line_2_is_data = c_q.v1[`B_QUAD];
  assign four_byte_address_select = c_q.v2[`B_ADDR4];
  assign read_latency_code = c_q.v2[2:0];
  assign read_dummy_cycles = c_q.dummy;
  assign read_mode_cycles = c_q.mode;
  assign blank_check_enable = c_q.v3[`B_BLANK];
  assign program_buffer_size_select = c_q.v3[`B_PROGRAM_BUFFER_SIZE_SELECT];
  assign prog_buffer_index = c_q.buf_idx;
  assign prot_active = c_q.prot_on;
  assign prot_first_sector = c_q.prot_first;
  assign prot_last_sector = c_q.prot_last;

  // ---------------- checks ----------------
  sequence s_write_arrives;
    (c_q.wr_s2 ^ c_q.wr_s3);
  endsequence

  sequence s_locked_write;
    (c_q.nv1[`B_PERM] || c_q.v1[`B_TEMP]) ##0 s_write_arrives;
  endsequence

  a_anchor_nv_locked: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_locked_write |=> $stable(c_q.nv1[`B_ANCHOR]))
    else $error("anchor changed while locked");

  a_anchor_vol_ro: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(protect_anchor_bottom))
    else $error("volatile anchor changed outside reset");

  a_perm_lock_otp: assert property (@(posedge core_clk)
    (c_q.nv1[`B_PERM] && !(sys_rst && power_up)) |=> c_q.nv1[`B_PERM])
    else $error("permanent lock cleared");

  a_temp_lock_reset: assert property (@(posedge core_clk)
    sys_rst |=> !temporary_lock)
    else $error("temporary lock survived reset");

  a_vol_reload_reset: assert property (@(posedge core_clk)
    sys_rst ##1 sys_rst |-> (c_q.v2 == c_q.nv2) && (c_q.v3 == c_q.nv3))
    else $error("volatile copies not reloaded");

  a_latency_dummy: assert property (@(posedge core_clk) disable iff (sys_rst)
    (read_kind == flash_cfg_pkg::RK_ARRAY) ##1 !sys_rst |->
      read_dummy_cycles == 4'h8 + {1'b0, $past(read_latency_code)})
    else $error("array latency wrong");

  a_fixed_dummy: assert property (@(posedge core_clk) disable iff (sys_rst)
    (read_kind == flash_cfg_pkg::RK_PARAM_TABLE || read_kind == flash_cfg_pkg::RK_UNIQUE_ID)
      |=> read_dummy_cycles == 4'h8)
    else $error("fixed dummy count wrong");

  a_quad_mode_two: assert property (@(posedge core_clk) disable iff (sys_rst)
    (read_kind == flash_cfg_pkg::RK_QUAD_IO) |=> read_mode_cycles == 2'h2)
    else $error("quad mode cycles wrong");

  a_buffer_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    !program_buffer_size_select ##1 !program_buffer_size_select |-> !prog_buffer_index[8])
    else $error("small buffer index escaped");

  a_prot_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
    (block_protect_size == 3'h0) |=> !prot_active)
    else $error("protection active at size zero");

  a_prot_top_end: assert property (@(posedge core_clk) disable iff (sys_rst)
    (block_protect_size == 3'h1 && !protect_anchor_bottom) |=> prot_first_sector == 8'hfc)
    else $error("top anchored range wrong");

  a_wel_cleared: assert property (@(posedge sclk) disable iff (l_q.rst_s2)
    (f_q.st == flash_cfg_pkg::ST_DIN && f_q.cnt == 6'h07 && l_q.wel &&
      f_q.idx <= `IDX_ERASE_VOL) |=> !l_q.wel)
    else $error("write enable kept after write");

endmodule

// ===== shared/flash_cfg_params.svh
// constants for the flash configuration register bank: indices, bit positions,
// defaults, masks, opcodes and cycle counts; included by the package and the rtl
`ifndef FLASH_CFG_PARAMS_SVH
`define FLASH_CFG_PARAMS_SVH

`define IDX_PROT_NV 3'h0
`define IDX_PROT_VOL 3'h1
`define IDX_ADDR_NV 3'h2
`define IDX_ADDR_VOL 3'h3
`define IDX_ERASE_NV 3'h4
`define IDX_ERASE_VOL 3'h5

`define PROT_NV_DEFAULT 8'h02
`define ADDR_NV_DEFAULT 8'h80
`define ERASE_NV_DEFAULT 8'h20
`define ADDR_WMASK 8'h87
`define ERASE_WMASK 8'h30

`define B_ANCHOR 5
`define B_PERM 4
`define B_QUAD 1
`define B_TEMP 0
`define B_ADDR4 7
`define B_BLANK 5
`define B_PROGRAM_BUFFER_SIZE_SELECT 4

`define LAT_BASE 4'h8
`define FIXED_DUMMY 4'h8
`define QUAD_MODE_CYC 2'h2
`define SECTOR_COUNT 9'h100
`define PROT_UNIT 9'h004
`define PROT_ALL_COUNT 9'h0fe

`define OPC_WR_ENABLE 8'h06
`define OPC_WR_DISABLE 8'h04
`define OPC_REG_WRITE 8'h71
`define OPC_REG_READ 8'h65
`define ADDR_BITS_3 6'h17
`define ADDR_BITS_4 6'h1f

`endif

// ===== shared/flash_cfg_pkg.sv
// types of the flash configuration register bank
// assumes flash_cfg_params.svh is on the include path
`include "flash_cfg_params.svh"
package flash_cfg_pkg;

  typedef enum logic [5:0] {
    ST_OPC = 6'h01,
    ST_ADDR = 6'h02,
    ST_DIN = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DOUT = 6'h10,
    ST_SKIP = 6'h20
  } frame_state_e;

  typedef enum logic [2:0] {
    RK_ARRAY = 3'h0,
    RK_QUAD_IO = 3'h1,
    RK_NV_REG = 3'h2,
    RK_VOL_REG = 3'h3,
    RK_PARAM_TABLE = 3'h4,
    RK_UNIQUE_ID = 3'h5
  } read_kind_e;

  typedef struct packed {
    logic [7:0] nv1, nv2, nv3, v1, v2, v3;
    logic [47:0] pub;
    logic pub_tgl, ack_s1, ack_s2, wr_s1, wr_s2, wr_s3;
    logic [3:0] dummy;
    logic [1:0] mode;
    logic [8:0] buf_idx;
    logic [7:0] prot_first, prot_last;
    logic prot_on;
  } core_s;

  typedef struct packed {
    frame_state_e st;
    logic [5:0] cnt;
    logic [7:0] opc, sh, dout;
    logic [2:0] idx;
  } frame_s;

  typedef struct packed {
    logic wel, wr_tgl;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [47:0] snap;
    logic tgl_s1, tgl_s2, tgl_seen, rst_s1, rst_s2;
  } link_s;

endpackage

// ===== bench/flash_host_model.sv
// host side model of the serial register link: frames on cs_n, sclk and si
// assumes the bank samples si and launches so on rising sclk
`timescale 1ns/1ps
module flash_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // launch while sclk is low, sample so just before the rise
  task automatic bit_out(input logic b, output logic s, output logic o);
    si = b;
    #3;
    s = so;
    o = so_oe;
    sclk = 1'h1;
    #3;
    sclk = 1'h0;
  endtask
  // oe[1]: so_oe before the last pre-data edge, oe[0]: at the first data bit
  task automatic frame(input logic [7:0] opc, input int nab, input logic [7:0] idx,
                       input int ndum, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic [1:0] oe);
    logic s;
    logic o;
    rd = 8'h00;
    oe = 2'h0;
    cs_n = 1'h0;
    #3;
    for (int i = 7; i >= 0; i--) bit_out(opc[i], s, o);
    for (int i = nab * 8 - 1; i >= 0; i--) bit_out(i < 8 ? idx[i] : 1'h0, s, o);
    if (nab > 0 && wr) begin
      for (int i = 7; i >= 0; i--) bit_out(wd[i], s, o);
    end else if (nab > 0) begin
      for (int i = 0; i < ndum; i++) bit_out(~si, s, o);
      oe[1] = o;
      for (int i = 7; i >= 0; i--) begin
        bit_out(~si, s, o);
        rd[i] = s;
        if (i == 7) oe[0] = o;
      end
    end
    #3;
    cs_n = 1'h1;
    si = ~si;
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench of the configuration register bank over its serial link
// assumes flash_host_model drives the link and core_clk runs at 10 MHz
`timescale 1ns/1ps
module tb_top;
  logic core_clk, sys_rst, power_up, sclk, cs_n, si, so, so_oe;
  flash_cfg_pkg::read_kind_e read_kind;
  logic [2:0] block_protect_size, lat;
  logic [15:0] prog_byte_offset, cfg;
  logic anchor, perm, temp, bpl, sal, quad, dl2, addr4, blank, pbuf, pact;
  logic [3:0] dum;
  logic [1:0] mode, oe;
  logic [8:0] pidx;
  logic [7:0] pfirst, plast, rd;
  logic [7:0] dflt [6] = '{8'h02, 8'h02, 8'h80, 8'h80, 8'h20, 8'h20};
  int miscompares = 0;
  int cmp_count = 0;
  int ab = 4;
  assign cfg = {3'h0, anchor, perm, temp, quad, dl2, addr4, lat, blank, pbuf, bpl, sal};
  flash_cfg_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .power_up(power_up),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .read_kind(read_kind),
    .block_protect_size(block_protect_size), .prog_byte_offset(prog_byte_offset),
    .protect_anchor_bottom(anchor), .permanent_lock(perm), .temporary_lock(temp),
    .block_protect_locked(bpl), .sector_arch_locked(sal), .four_bit_io_select(quad),
    .data_line_2_is_data(dl2), .four_byte_address_select(addr4),
    .read_latency_code(lat), .read_dummy_cycles(dum), .read_mode_cycles(mode),
    .blank_check_enable(blank), .program_buffer_size_select(pbuf),
    .prog_buffer_index(pidx), .prot_active(pact), .prot_first_sector(pfirst),
    .prot_last_sector(plast));
  flash_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.frame(8'h06, 0, 8'h00, 0, 1'h0, 8'h00, rd, oe);
    cyc(6);
    host.frame(8'h71, ab, idx, 0, 1'h1, d, rd, oe);
    cyc(10);
  endtask
  task automatic rdr(input logic [7:0] idx, input int ndum, input logic [7:0] exp);
    host.frame(8'h04, 0, 8'h00, 0, 1'h0, 8'h00, rd, oe);
    cyc(6);
    host.frame(8'h65, ab, idx, ndum, 1'h0, 8'h00, rd, oe);
    cyc(6);
    chk("register", {8'h00, exp}, {8'h00, rd});
    chk("read timing", 16'h0001, {14'h0000, oe});
  endtask
  task automatic rst(input int n);
    sys_rst <= 1'h1;
    cyc(n);
    sys_rst <= 1'h0;
    cyc(8);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(20000);
    miscompares++;
    results();
  end
  initial begin
    sys_rst = 1'h1;
    power_up = 1'h1;
    read_kind = flash_cfg_pkg::RK_ARRAY;
    block_protect_size = 3'h0;
    prog_byte_offset = 16'h03ff;
    cyc(10);
    // clock the link during reset so its side is cleared too
    host.frame(8'h04, 0, 8'h00, 0, 1'h0, 8'h00, rd, oe);
    cyc(10);
    sys_rst <= 1'h0;
    power_up <= 1'h0;
    cyc(8);
    chk("config", 16'h0388, cfg);
    chk("protect", 16'h0000, {15'h0000, pact});
    for (int i = 0; i < 6; i++) rdr(8'(i), (i % 2 == 0) ? 8 : 0, dflt[i]);
    host.frame(8'h65, ab, 8'h06, 0, 1'h0, 8'h00, rd, oe);
    chk("unmapped", 16'h0000, {8'h00, rd});
    $display("test end: defaults");
    host.frame(8'h71, ab, 8'h05, 0, 1'h1, 8'h10, rd, oe);
    cyc(10);
    rdr(8'h05, 0, 8'h20);
    wr(8'h05, 8'h10);
    chk("erase buffer", 16'h03ff, {5'h00, blank, pbuf, pidx});
    wr(8'h05, 8'h20);
    chk("erase buffer", 16'h04ff, {5'h00, blank, pbuf, pidx});
    $display("test end: erase and buffer");
    for (int c = 0; c < 8; c++) begin
      wr(8'h03, 8'h80 | 8'(c));
      chk("latency", 16'(c), {13'h0000, lat});
      rdr(8'h02, c + 8, 8'h80);
      for (int k = 0; k < 6; k++) begin
        if (k != 3) begin
          read_kind <= flash_cfg_pkg::read_kind_e'(k);
          cyc(2);
          chk("dummy", (k > 3) ? 16'h0008 : 16'(c + 8), {12'h000, dum});
          chk("mode", (k == 1) ? 16'h0002 : 16'h0000, {14'h0000, mode});
        end
      end
    end
    wr(8'h03, 8'h00);
    ab = 3;
    chk("address", 16'h0000, {15'h0000, addr4});
    rdr(8'h03, 0, 8'h00);
    wr(8'h03, 8'h80);
    ab = 4;
    $display("test end: latency and address");
    wr(8'h01, 8'h00);
    chk("io width", 16'h0000, {14'h0000, quad, dl2});
    rdr(8'h01, 0, 8'h00);
    block_protect_size <= 3'h1;
    cyc(2);
    chk("range", 16'hfcff, {pfirst, plast});
    chk("protect", 16'h0001, {15'h0000, pact});
    wr(8'h01, 8'h03);
    chk("temp lock", 16'h0003, {14'h0000, temp, bpl});
    wr(8'h00, 8'h22);
    rdr(8'h00, 8, 8'h02);
    rst(4);
    chk("temp lock", 16'h0000, {14'h0000, temp, bpl});
    $display("test end: width and temporary lock");
    wr(8'h00, 8'h22);
    rdr(8'h00, 8, 8'h22);
    wr(8'h01, 8'h22);
    chk("anchor", 16'h0000, {15'h0000, anchor});
    rst(4);
    chk("anchor", 16'h0001, {15'h0000, anchor});
    chk("range", 16'h0003, {pfirst, plast});
    wr(8'h00, 8'h32);
    chk("perm lock", 16'h0003, {14'h0000, bpl, sal});
    wr(8'h00, 8'h02);
    rdr(8'h00, 8, 8'h32);
    rst(4);
    chk("perm lock", 16'h0001, {15'h0000, perm});
    $display("test end: anchor and permanent lock");
    results();
  end
endmodule
